// [verilog/rsif_pkg.sv]
`default_nettype none
package rsif_pkg;

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADR_MSB = 7;
	localparam int DAT_W   = 32;

	// word indices; byte address is four times the index
	localparam logic [5:0] WIX_STAT0    = 6'h00;
	localparam logic [5:0] WIX_STAT1    = 6'h01;
	localparam logic [5:0] WIX_CMD0     = 6'h02;
	localparam logic [5:0] WIX_CMD1     = 6'h03;
	localparam logic [5:0] WIX_IMG      = 6'h04;
	localparam logic [5:0] WIX_IMG_LAST = 6'h13;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_READY  = 0;
	localparam int B_SHORT  = 1;
	localparam int B_SUPPLY = 3;
	localparam int B_BREAK  = 4;
	localparam int B_ALARM  = 0;
	localparam int B_PDONE  = 1;
	localparam int B_PERR   = 2;
	localparam int B_BUSY   = 4;
	localparam int B_ERRCLR = 0;
	localparam int B_ADCMD  = 1;
	localparam int B_PACC   = 0;
	localparam int B_PRD    = 1;
	localparam int B_PWR    = 2;
	localparam int PCMD_W   = 3;

	// ----------------------------------------
	// input image
	// ----------------------------------------
	localparam int IMG_PTS    = 256;
	localparam int IMG_WORD_W = 16;
	localparam int IMG_IDX_W  = 4;

	// ----------------------------------------
	// synchronised pin vector slots
	// ----------------------------------------
	localparam int P_PGOOD  = 0;
	localparam int P_TEST   = 1;
	localparam int P_FAULT  = 2;
	localparam int P_SHORT  = 3;
	localparam int P_OVERC  = 4;
	localparam int P_SUPPLY = 5;
	localparam int P_BREAK  = 6;
	localparam int P_LOST   = 7;
	localparam int P_SSTAT  = 8;
	localparam int P_SADDR  = 9;
	localparam int N_PIN    = 10;

endpackage
`default_nettype wire

// [verilog/rsif_status.sv]
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsif_status (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// wishbone classic slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:2]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// asynchronous condition pins
	input  wire logic                     power_good,
	input  wire logic                     self_test_done,
	input  wire logic                     hw_fault,
	input  wire logic                     line_short_detect,
	input  wire logic                     overcurrent_detect,
	input  wire logic                     supply_low_detect,
	input  wire logic                     line_break_detect,
	input  wire logic                     slave_lost_detect,
	input  wire logic                     slave_status_fault,
	input  wire logic                     slave_addr_fault,
	// on-chip link engines
	input  wire logic                     param_done_pulse,
	input  wire logic                     param_fail_pulse,
	input  wire logic                     addr_detect_done,
	input  wire logic [255:0]             slave_input_states,
	// status and commands toward the engines
	output logic                          station_ready,
	output logic                          addr_detect_busy,
	output logic                          addr_detect_start,
	output logic                          param_access_command,
	output logic                          param_batch_read_command,
	output logic                          param_batch_write_command
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [rsif_pkg::N_PIN-1:0]  pin_s1;
		logic [rsif_pkg::N_PIN-1:0]  pin_s2;
		logic                        ready;
		logic                        short_err;
		logic                        supply_err;
		logic                        break_err;
		logic                        alarm;
		logic                        pdone;
		logic                        perr;
		logic                        busy;
		logic                        ad_start;
		logic                        errclr;
		logic                        adcmd;
		logic [rsif_pkg::PCMD_W-1:0] pcmd;
		logic                        ack;
		logic [31:0]                 dat;
		logic [255:0]                img;
	} rsif_state_t;

	localparam rsif_state_t S_RST = '0;

	rsif_state_t s_r;
	rsif_state_t s_nxt;

	logic [rsif_pkg::N_PIN-1:0]  pin_vec;
	logic                        bus_req;
	logic                        wr_cmd0;
	logic                        wr_cmd1;
	logic                        clr_fall;
	logic                        ad_fall;
	logic                        pcmd_rise;
	logic                        c_short;
	logic                        c_supply;
	logic                        c_break;
	logic                        c_alarm;
	logic                        img_hit;
	logic [5:0]                  img_rel;
	logic [rsif_pkg::IMG_IDX_W-1:0] img_word;
	logic [15:0]                 img_slice;
	logic [31:0]                 rd_val;

	// ----------------------------------------
	// pin gathering and bus decode
	// ----------------------------------------
	// pins enter one vector so one two-stage synchroniser serves all
	assign pin_vec = {slave_addr_fault, slave_status_fault, slave_lost_detect,
		line_break_detect, supply_low_detect, overcurrent_detect,
		line_short_detect, hw_fault, self_test_done, power_good};

	// request seen in its first cycle only; ack then ends it
	assign bus_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
	assign wr_cmd0 = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == rsif_pkg::WIX_CMD0);
	assign wr_cmd1 = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == rsif_pkg::WIX_CMD1);

	// host pulses: on-then-off of the clear and detect bits
	assign clr_fall = wr_cmd0 & s_r.errclr & ~wb_dat_i[rsif_pkg::B_ERRCLR];
	assign ad_fall  = wr_cmd0 & s_r.adcmd & ~wb_dat_i[rsif_pkg::B_ADCMD];
	assign pcmd_rise = wr_cmd1 & (|(~s_r.pcmd & wb_dat_i[rsif_pkg::PCMD_W-1:0]));

	// causes, read from the second synchroniser stage only
	assign c_short  = s_r.pin_s2[rsif_pkg::P_SHORT] | s_r.pin_s2[rsif_pkg::P_OVERC];
	assign c_supply = s_r.pin_s2[rsif_pkg::P_SUPPLY];
	assign c_break  = s_r.pin_s2[rsif_pkg::P_BREAK] | s_r.pin_s2[rsif_pkg::P_LOST];
	assign c_alarm  = s_r.pin_s2[rsif_pkg::P_SSTAT] | s_r.pin_s2[rsif_pkg::P_SADDR];

	// image word select: point k sits in word k/16, bit k%16
	assign img_hit   = (wb_adr_i >= rsif_pkg::WIX_IMG) && (wb_adr_i <= rsif_pkg::WIX_IMG_LAST);
	assign img_rel   = wb_adr_i - rsif_pkg::WIX_IMG;
	assign img_word  = img_rel[rsif_pkg::IMG_IDX_W-1:0];
	assign img_slice = s_r.img[img_word*rsif_pkg::IMG_WORD_W +: rsif_pkg::IMG_WORD_W];

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// unmapped words read zero and are still acknowledged
	always_comb begin
		rd_val = '0;
		if (img_hit) begin
			rd_val[15:0] = img_slice;
		end else begin
			unique case (wb_adr_i)
				rsif_pkg::WIX_STAT0: begin
					rd_val[rsif_pkg::B_READY]  = s_r.ready;
					rd_val[rsif_pkg::B_SHORT]  = s_r.short_err;
					rd_val[rsif_pkg::B_SUPPLY] = s_r.supply_err;
					rd_val[rsif_pkg::B_BREAK]  = s_r.break_err;
				end
				rsif_pkg::WIX_STAT1: begin
					rd_val[rsif_pkg::B_ALARM] = s_r.alarm;
					rd_val[rsif_pkg::B_PDONE] = s_r.pdone;
					rd_val[rsif_pkg::B_PERR]  = s_r.perr;
					rd_val[rsif_pkg::B_BUSY]  = s_r.busy;
				end
				rsif_pkg::WIX_CMD0: begin
					rd_val[rsif_pkg::B_ERRCLR] = s_r.errclr;
					rd_val[rsif_pkg::B_ADCMD]  = s_r.adcmd;
				end
				rsif_pkg::WIX_CMD1: begin
					rd_val[rsif_pkg::PCMD_W-1:0] = s_r.pcmd;
				end
				default: begin
					rd_val = '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// every error flag: live cause sets, clear pulse drops it; set wins
	always_comb begin
		s_nxt = s_r;
		s_nxt.pin_s1 = pin_vec;
		s_nxt.pin_s2 = s_r.pin_s1;

		// ready needs power and test done, and no hardware failure
		s_nxt.ready = s_r.pin_s2[rsif_pkg::P_PGOOD] & s_r.pin_s2[rsif_pkg::P_TEST]
			& ~s_r.pin_s2[rsif_pkg::P_FAULT];

		s_nxt.short_err  = c_short | (s_r.short_err & ~clr_fall);
		s_nxt.supply_err = c_supply | (s_r.supply_err & ~clr_fall);
		s_nxt.break_err  = c_break | (s_r.break_err & ~clr_fall);
		s_nxt.alarm      = c_alarm | (s_r.alarm & ~clr_fall);
		s_nxt.perr       = param_fail_pulse | (s_r.perr & ~clr_fall);

		// done flag: completion sets, any newly raised command clears
		s_nxt.pdone = param_done_pulse | (s_r.pdone & ~pcmd_rise);

		// detection busy from the start pulse until the engine ends
		s_nxt.busy     = ad_fall | (s_r.busy & ~addr_detect_done);
		s_nxt.ad_start = ad_fall;

		// command registers
		if (wr_cmd0) begin
			s_nxt.errclr = wb_dat_i[rsif_pkg::B_ERRCLR];
			s_nxt.adcmd  = wb_dat_i[rsif_pkg::B_ADCMD];
		end
		if (wr_cmd1) begin
			s_nxt.pcmd = wb_dat_i[rsif_pkg::PCMD_W-1:0];
		end

		// one-cycle ack; read data registered with it
		s_nxt.ack = bus_req;
		s_nxt.dat = (bus_req & ~wb_we_i) ? rd_val : '0;

		// input image follows the slaves every cycle
		s_nxt.img = slave_input_states;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// module reset drops every flag and the stored image
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= S_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o                  = s_r.ack;
	assign wb_dat_o                  = s_r.dat;
	assign station_ready             = s_r.ready;
	assign addr_detect_busy          = s_r.busy;
	assign addr_detect_start         = s_r.ad_start;
	assign param_access_command      = s_r.pcmd[rsif_pkg::B_PACC];
	assign param_batch_read_command  = s_r.pcmd[rsif_pkg::B_PRD];
	assign param_batch_write_command = s_r.pcmd[rsif_pkg::B_PWR];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence ready_cond_s;
		s_r.pin_s2[rsif_pkg::P_PGOOD] && s_r.pin_s2[rsif_pkg::P_TEST]
			&& !s_r.pin_s2[rsif_pkg::P_FAULT];
	endsequence

	sequence detect_start_s;
		ad_fall;
	endsequence

	sequence detect_end_s;
		addr_detect_done && !ad_fall;
	endsequence

	// start strobe lasts exactly one cycle
	sequence start_once_s;
		addr_detect_start ##1 !addr_detect_start;
	endsequence

	ready_rise_a: assert property (ready_cond_s |=> station_ready)
		else $error("ready not raised");
	ready_fault_a: assert property (s_r.pin_s2[rsif_pkg::P_FAULT] |=> !station_ready)
		else $error("ready kept on fault");
	short_set_a: assert property (line_short_detect ##2 1 |=> s_r.short_err)
		else $error("short flag not set");
	short_hold_a: assert property (s_r.short_err && !clr_fall |=> s_r.short_err)
		else $error("short flag lost");
	supply_flag_a: assert property (supply_low_detect ##2 1 |=> s_r.supply_err)
		else $error("supply flag not set");
	supply_hold_a: assert property (s_r.supply_err && !clr_fall |=> s_r.supply_err)
		else $error("supply flag lost");
	break_flag_a: assert property (slave_lost_detect ##2 1 |=> s_r.break_err)
		else $error("break flag not set");
	break_hold_a: assert property (s_r.break_err && !clr_fall |=> s_r.break_err)
		else $error("break flag lost");
	alarm_flag_a: assert property (slave_addr_fault ##2 1 |=> s_r.alarm)
		else $error("alarm flag not set");
	alarm_hold_a: assert property (s_r.alarm && !clr_fall |=> s_r.alarm)
		else $error("alarm flag lost");
	done_set_a: assert property (param_done_pulse |=> s_r.pdone ##1 (s_r.pdone || $past(pcmd_rise)))
		else $error("done flag not set");
	perr_flag_a: assert property (param_fail_pulse ##1 !clr_fall |=> s_r.perr)
		else $error("parameter error lost");
	detect_busy_a: assert property (detect_start_s |=> addr_detect_busy)
		else $error("busy not raised");
	detect_end_a: assert property (detect_end_s |=> !addr_detect_busy)
		else $error("busy not dropped");
	image_copy_a: assert property (1'b1 |=> s_r.img == $past(slave_input_states))
		else $error("image not copied");
	image_read_a: assert property (bus_req && !wb_we_i && img_hit |=> wb_ack_o
		&& wb_dat_o[15:0] == $past(img_slice) && wb_dat_o[31:16] == '0)
		else $error("image word wrong");
	done_clear_a: assert property (pcmd_rise && !param_done_pulse |=> !s_r.pdone)
		else $error("done flag not cleared");
	clear_fall_a: assert property (clr_fall && !c_short |=> !s_r.short_err)
		else $error("short flag not cleared");
	cause_stay_a: assert property (clr_fall && c_alarm |=> s_r.alarm)
		else $error("live alarm cleared");
	overc_set_a: assert property (overcurrent_detect ##2 1 |=> s_r.short_err)
		else $error("overcurrent not flagged");
	pair_break_a: assert property (line_break_detect ##2 1 |=> s_r.break_err)
		else $error("pair break not flagged");
	status_alarm_a: assert property (slave_status_fault ##2 1 |=> s_r.alarm)
		else $error("status alarm not flagged");
	supply_clear_a: assert property (clr_fall && !c_supply |=> !s_r.supply_err)
		else $error("supply flag not cleared");
	break_clear_a: assert property (clr_fall && !c_break |=> !s_r.break_err)
		else $error("break flag not cleared");
	alarm_clear_a: assert property (clr_fall && !c_alarm |=> !s_r.alarm)
		else $error("alarm flag not cleared");
	perr_clear_a: assert property (clr_fall && !param_fail_pulse |=> !s_r.perr)
		else $error("parameter error not cleared");
	perr_hold_a: assert property (s_r.perr && !clr_fall |=> s_r.perr)
		else $error("parameter error dropped");
	short_stay_a: assert property (clr_fall && c_short |=> s_r.short_err)
		else $error("live short cleared");
	supply_stay_a: assert property (clr_fall && c_supply |=> s_r.supply_err)
		else $error("live supply error cleared");
	break_stay_a: assert property (clr_fall && c_break |=> s_r.break_err)
		else $error("live break cleared");
	done_hold_a: assert property (s_r.pdone && !pcmd_rise |=> s_r.pdone)
		else $error("done flag dropped");
	detect_pulse_a: assert property (detect_start_s |=> start_once_s)
		else $error("start strobe malformed");
	ack_answer_a: assert property (bus_req |=> wb_ack_o)
		else $error("request not acknowledged");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data outside ack");
	cmd_write_a: assert property (wr_cmd0 |=> s_r.errclr == $past(wb_dat_i[rsif_pkg::B_ERRCLR]))
		else $error("clear bit not written");
	reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		rst |=> !(s_r.short_err || s_r.supply_err || s_r.break_err || s_r.alarm || s_r.perr))
		else $error("flags survive reset");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than a cycle");

endmodule
`default_nettype wire

// [tb/rsif_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rsif_engine_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// requests from the block
	input  wire logic       addr_detect_start,
	input  wire logic [2:0] pcmd,
	// answer delay and failure choice
	input  wire logic [3:0] dly,
	input  wire logic       fail_en,
	// answers to the block
	output logic            param_done_pulse,
	output logic            param_fail_pulse,
	output logic            addr_detect_done
);
	logic [2:0] pcmd_q;
	int         pcnt;
	int         acnt;
	// a new command or detection start is answered dly+2 cycles after it is seen
	always_ff @(posedge clk_sys) begin
		pcmd_q <= pcmd;
		param_done_pulse <= !rst && pcnt == 1 && !fail_en;
		param_fail_pulse <= !rst && pcnt == 1 && fail_en;
		addr_detect_done <= !rst && acnt == 1;
		pcnt <= ((pcmd & ~pcmd_q) != 3'h0) ? int'(dly) + 2 : (pcnt > 0 ? pcnt - 1 : 0);
		acnt <= addr_detect_start ? int'(dly) + 2 : (acnt > 0 ? acnt - 1 : 0);
		if (rst) begin
			pcnt <= 0;
			acnt <= 0;
		end
	end
endmodule
`default_nettype wire

// [tb/test_remote_status_input_flags.sv]
`timescale 1ns/1ps
`default_nettype none
module test_remote_status_input_flags;
	logic         clk_sys = 1'b0;
	logic         rst     = 1'b1;
	logic         wb_cyc  = 1'b0;
	logic         wb_stb  = 1'b0;
	logic         wb_we   = 1'b0;
	logic [5:0]   wb_adr  = 6'h00;
	logic [3:0]   wb_sel  = 4'h0;
	logic [31:0]  wb_dat  = 32'h0;
	logic [31:0]  wb_dat_o;
	logic         wb_ack_o;
	logic         pgood   = 1'b0;
	logic         tdone   = 1'b0;
	logic         fault   = 1'b0;
	logic [6:0]   cz      = 7'h00;
	logic [255:0] sin     = '0;
	logic [3:0]   dly     = 4'h4;
	logic         fail_en = 1'b0;
	logic         pdone;
	logic         pfail;
	logic         adone;
	logic         start;
	logic         rdy;
	logic         bsy;
	wire  [2:0]   pcmd;
	int           num_errors = 0;
	int           checked    = 0;
	int           seed       = 32'hc2d5;
	logic [4:0]   fl         = 5'h00;
	logic         done_e     = 1'b0;
	logic [31:0]  q;
	logic [6:0]   c;
	logic [6:0]   k;

	rsif_status rsif_status_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .power_good(pgood), .self_test_done(tdone), .hw_fault(fault),
		.line_short_detect(cz[0]), .overcurrent_detect(cz[1]), .supply_low_detect(cz[2]),
		.line_break_detect(cz[3]), .slave_lost_detect(cz[4]), .slave_status_fault(cz[5]),
		.slave_addr_fault(cz[6]), .param_done_pulse(pdone), .param_fail_pulse(pfail),
		.addr_detect_done(adone), .slave_input_states(sin), .station_ready(rdy), .addr_detect_busy(bsy),
		.addr_detect_start(start), .param_access_command(pcmd[0]),
		.param_batch_read_command(pcmd[1]), .param_batch_write_command(pcmd[2]));
	rsif_engine_model rsif_engine_model_i (.clk_sys(clk_sys), .rst(rst), .addr_detect_start(start),
		.pcmd(pcmd), .dly(dly), .fail_en(fail_en), .param_done_pulse(pdone),
		.param_fail_pulse(pfail), .addr_detect_done(adone));

	// free running system clock
	initial forever #2 clk_sys = ~clk_sys;

	// expected status words from the flag model
	function automatic logic [31:0] s0(input logic r);
		return {27'h0, fl[2], fl[1], 1'b0, fl[0], r};
	endfunction
	function automatic logic [31:0] s1(input logic b);
		return {27'h0, b, 1'b0, fl[4], done_e, fl[3]};
	endfunction
	function automatic logic [3:0] fmap(input logic [6:0] v);
		return {v[5] | v[6], v[3] | v[4], v[2], v[0] | v[1]};
	endfunction

	// comparison, bus cycles and verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_sys);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic clr();
		wb(rsif_pkg::WIX_CMD0, 1'b1, 32'h1);
		wb(rsif_pkg::WIX_CMD0, 1'b1, 32'h0);
	endtask
	task automatic conclude();
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(rsif_pkg::WIX_STAT0, 32'h0);
		chk(32'(rdy), 32'h0);
		pgood <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(rsif_pkg::WIX_STAT0, 32'h0);
		tdone <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(rsif_pkg::WIX_STAT0, s0(1'b1));
		chk(32'(rdy), 32'h1);
		fault <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(rsif_pkg::WIX_STAT0, s0(1'b0));
		chk(32'(rdy), 32'h0);
		fault <= 1'b0;
		repeat (6) @(posedge clk_sys);
		// random causes, then a clear pulse with some causes still live
		for (int i = 0; i < 10; i++) begin
			c = (i == 0) ? 7'h7f : 7'($random(seed));
			k = (i == 0) ? 7'h00 : 7'($random(seed));
			cz <= c;
			repeat (5) @(posedge clk_sys);
			cz <= c & k;
			fl[3:0] = fl[3:0] | fmap(c);
			repeat (5) @(posedge clk_sys);
			rd(rsif_pkg::WIX_STAT0, s0(1'b1));
			rd(rsif_pkg::WIX_STAT1, s1(1'b0));
			clr();
			fl[3:0] = fmap(c & k);
			rd(rsif_pkg::WIX_STAT0, s0(1'b1));
			rd(rsif_pkg::WIX_STAT1, s1(1'b0));
			cz <= 7'h00;
			@(posedge clk_sys);
		end
		// each parameter command, answered slowly, first good then failing
		for (int j = 0; j < 6; j++) begin
			dly <= 4'(4 + ($random(seed) & 7));
			fail_en <= j >= 3;
			wb(rsif_pkg::WIX_CMD1, 1'b1, 32'(1 << (j % 3)));
			chk(32'(pcmd), 32'(1 << (j % 3)));
			done_e = 1'b0;
			rd(rsif_pkg::WIX_STAT1, s1(1'b0));
			repeat (16) @(posedge clk_sys);
			done_e = j < 3;
			fl[4] = j >= 3;
			rd(rsif_pkg::WIX_STAT1, s1(1'b0));
			wb(rsif_pkg::WIX_CMD1, 1'b1, 32'h0);
		end
		clr();
		fl = 5'h00;
		rd(rsif_pkg::WIX_STAT1, s1(1'b0));
		// address detection run
		dly <= 4'ha;
		wb(rsif_pkg::WIX_CMD0, 1'b1, 32'h2);
		wb(rsif_pkg::WIX_CMD0, 1'b1, 32'h0);
		rd(rsif_pkg::WIX_STAT1, s1(1'b1));
		chk(32'(bsy), 32'h1);
		repeat (20) @(posedge clk_sys);
		rd(rsif_pkg::WIX_STAT1, s1(1'b0));
		chk(32'(bsy), 32'h0);
		// input image, a two point slave at address 10 first
		for (int p = 0; p < 2; p++) begin
			for (int w = 0; w < 8; w++)
				sin[w*32+:32] <= (p == 1) ? 32'($random(seed)) : ((w == 0) ? 32'hc00 : 32'h0);
			repeat (3) @(posedge clk_sys);
			for (int w = 0; w < 16; w++)
				rd(6'(rsif_pkg::WIX_IMG + w), {16'h0, sin[w*16+:16]});
		end
		// read-only and unmapped places
		wb(6'h3f, 1'b1, 32'hffffffff);
		wb(rsif_pkg::WIX_STAT0, 1'b1, 32'hffffffff);
		rd(6'h3f, 32'h0);
		rd(rsif_pkg::WIX_STAT0, s0(1'b1));
		// sticky flags dropped by a module reset
		cz <= 7'h7f;
		repeat (5) @(posedge clk_sys);
		cz <= 7'h00;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		done_e = 1'b0;
		repeat (6) @(posedge clk_sys);
		rd(rsif_pkg::WIX_STAT0, s0(1'b1));
		rd(rsif_pkg::WIX_STAT1, s1(1'b0));
		conclude();
	end
endmodule
`default_nettype wire
